// *** tb/ee_model.sv ***
`timescale 1ns/1ns
module ee_model (
   // i2c wires
   input  wire logic scl,
   input  wire logic sda,
   // test control and the data-line pull-down
   input  wire logic present,
   output logic      sda_oe
);
   logic [7:0] mem [0:47];
   logic [7:0] sh, ptr;
   logic       rd, tx, mack;
   int         bitn = -1;
   int         nb;
   initial sda_oe = 1'b0;
   // no write path: the device side never programs this memory
   always @(negedge sda) if (scl === 1'b1) begin
      bitn = 0;
      nb = 0;
      rd = 1'b0;
      tx = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      bitn = -1;
      sda_oe = 1'b0;
   end
   always @(posedge scl) if (bitn >= 0) begin
      if (bitn < 8 && !rd) sh = {sh[6:0], sda};
      if (bitn == 8) mack = !sda;
      bitn++;
   end
   always @(negedge scl) if (bitn > 0) begin
      if (bitn == 8) begin
         if (!rd) begin
            sda_oe = present && (nb != 0 || sh == 8'ha0 || sh == 8'ha1);
            if (nb == 0 && sh == 8'ha1) rd = 1'b1;
            if (nb == 2) ptr = sh;
            nb++;
         end else begin
            sda_oe = 1'b0;
         end
      end else if (bitn == 9) begin
         bitn = 0;
         sda_oe = 1'b0;
         if (rd && (!tx || mack)) begin
            tx = 1'b1;
            sh = mem[ptr];
            ptr++;
            sda_oe = !sh[7];
         end else if (rd) begin
            bitn = -1;
         end
      end else if (tx) begin
         sda_oe = !sh[7 - bitn];
      end
   end
endmodule : ee_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   import cfg_loader_pkg::*;
   logic        clk_sys, reset_n, wr_en, rd_en, on_request, off_request;
   logic        power_on, startup_fail, busy, cmd_done, cmd_err;
   logic        scl_oe, sda_oe, ee_oe, strap_low, present;
   logic [15:0] addr, wr_data, rd_data;
   int          err_count, compares;
   // pull-ups on both pins; strap_low stands for a board without the strap
   wire         scl_w = ~(scl_oe | strap_low);
   wire         sda_w = ~(sda_oe | ee_oe);

   bootstrap_config_loader dut_u (
      .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .on_request(on_request),
      .off_request(off_request), .power_on(power_on), .startup_fail(startup_fail),
      .busy(busy), .cmd_done(cmd_done), .cmd_err(cmd_err),
      .aux_serial_clock_pin_in(scl_w), .aux_serial_clock_pin_out(),
      .aux_serial_clock_pin_oe(scl_oe), .aux_serial_data_pin_in(sda_w),
      .aux_serial_data_pin_out(), .aux_serial_data_pin_oe(sda_oe));
   ee_model ee_u (.scl(scl_w), .sda(sda_w), .present(present), .sda_oe(ee_oe));

   always #50 clk_sys = ~clk_sys;

   function automatic logic [15:0] win(input int k);
      return REG_WIN_BASE + 16'(k);
   endfunction : win

   task automatic print_verdict();
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk_sys);
      wr_en   <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #10;
      chk(rd_data, exp);
   endtask : rdc

   // the register map is left alone until busy drops
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge clk_sys);
      #10;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge clk_sys);
         #10;
         n++;
      end
      if (n >= 20000) err_count++;
      repeat (2) @(posedge clk_sys);
      #10;
   endtask : wait_idle

   task automatic cmd(input logic [15:0] v, input logic err);
      wr(REG_OTP_CTRL, v);
      wait_idle();
      chk({14'h0, cmd_done, cmd_err}, {14'h0, 1'b1, err});
      wr(REG_STATUS, 16'h0003);
   endtask : cmd

   task automatic start(input logic dev, input logic p_on, input logic p_fail);
      @(posedge clk_sys);
      strap_low <= !dev;
      repeat (4) @(posedge clk_sys);
      on_request <= 1'b1;
      @(posedge clk_sys);
      on_request <= 1'b0;
      @(posedge clk_sys);
      #10;
      chk({15'h0, busy}, 16'h0001);
      wait_idle();
      chk({14'h0, power_on, startup_fail}, {14'h0, p_on, p_fail});
      if (power_on === 1'b1) begin
         @(posedge clk_sys);
         off_request <= 1'b1;
         @(posedge clk_sys);
         off_request <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask : start

   initial begin
      #(100 * 30000);
      err_count++;
      print_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      {wr_en, rd_en, on_request, off_request} = 4'h0;
      addr = 16'h0000;
      wr_data = 16'h0000;
      strap_low = 1'b1;
      present = 1'b1;
      err_count = 0;
      compares = 0;
      for (int i = 0; i < 48; i++) ee_u.mem[i] = 8'(8'h30 + i);
      ee_u.mem[32] = 8'ha5;
      ee_u.mem[33] = 8'h96;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      rdc(REG_RESET_RELOAD, 16'h8000);
      wr(REG_RESET_RELOAD, 16'h0000);
      rdc(REG_RESET_RELOAD, 16'h8000);
      wr(win(0), 16'h1234);
      rdc(win(0), 16'h0000);
      start(1'b0, 1'b0, 1'b1);
      for (int k = 16; k < 32; k++) wr(win(k), 16'(16'h1000 + k));
      cmd(16'h2202, 1'b0);
      cmd(16'h2203, 1'b0);
      cmd(16'h2482, 1'b0);
      wr(win(17), 16'hbeef);
      cmd(16'h2482, 1'b1);
      cmd(16'h0202, 1'b1);
      cmd(16'h2200, 1'b1);
      cmd(16'h2120, 1'b0);
      rdc(win(17), 16'h1011);
      wr(win(18), 16'hdead);
      start(1'b0, 1'b1, 1'b0);
      rdc(win(18), 16'h1012);
      start(1'b1, 1'b1, 1'b0);
      for (int k = 0; k < 24; k++) rdc(win(16 + k), {ee_u.mem[2*k], ee_u.mem[2*k+1]});
      wr(win(20), 16'h0000);
      cmd(16'h0120, 1'b0);
      rdc(win(20), 16'h3839);
      ee_u.mem[33] = 8'h97;
      start(1'b1, 1'b0, 1'b1);
      ee_u.mem[33] = 8'h96;
      present = 1'b0;
      start(1'b1, 1'b0, 1'b1);
      wr(REG_SECURITY, UNLOCK_CODE);
      wr(REG_RESET_RELOAD, 16'h0000);
      rdc(REG_RESET_RELOAD, 16'h0000);
      wr(win(32), VALID_MARKER);
      wr(win(16), 16'h0042);
      start(1'b1, 1'b1, 1'b0);
      wr(win(16), 16'h0000);
      start(1'b1, 1'b0, 1'b1);
      start(1'b0, 1'b0, 1'b1);
      cmd(16'h2802, 1'b0);
      cmd(16'h2120, 1'b0);
      wr(win(24), 16'h1108);
      cmd(16'h2203, 1'b0);
      cmd(16'h2483, 1'b1);
      print_verdict();
   end
endmodule : tb_top

// *** verilog/bootstrap_config_loader.sv ***
`timescale 1ns/1ns
module bootstrap_config_loader
   import cfg_loader_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // register port
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [15:0] rd_data,
   // power sequencing
   input  wire logic        on_request,
   input  wire logic        off_request,
   output logic             power_on,
   output logic             startup_fail,
   output logic             busy,
   // command outcome
   output logic             cmd_done,
   output logic             cmd_err,
   // aux serial pins
   input  wire logic        aux_serial_clock_pin_in,
   output logic             aux_serial_clock_pin_out,
   output logic             aux_serial_clock_pin_oe,
   input  wire logic        aux_serial_data_pin_in,
   output logic             aux_serial_data_pin_out,
   output logic             aux_serial_data_pin_oe
);

   logic [15:0] win_r [WIN_WORDS];
   logic [15:0] otp_r [OTP_WORDS];
   state_t      state_r;
   op_t         op_r;
   otp_cmd_t    cmd_r;
   logic        ctx_cmd_r, dev_r, rl_r, reload_r, unlock_r, errp_r, nack_r;
   logic        done_f_r, err_f_r, fail_r, power_on_r, busy_r;
   logic [5:0]  idx_r, end_r, step_r;
   logic [15:0] rd_data_r;
   logic        scl_s1, scl_s2, sda_s1, sda_s2;
   logic [4:0]  div_r;
   logic [1:0]  ph_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r, hi_r;
   logic        scl_oe_r, sda_oe_r;

   // register decode
   otp_cmd_t    cmd;
   logic        idle, wr_reload, wr_key, wr_stat, wr_cmd, win_hit, start_go, cmd_go;
   logic [15:0] win_off;
   logic [5:0]  win_aidx;
   assign cmd       = otp_cmd_t'(wr_data);
   assign idle      = (state_r == S_IDLE);
   assign wr_reload = wr_en && addr == REG_RESET_RELOAD;
   assign wr_key    = wr_en && addr == REG_SECURITY;
   assign wr_stat   = wr_en && addr == REG_STATUS;
   assign wr_cmd    = wr_en && addr == REG_OTP_CTRL;
   assign win_off   = addr - REG_WIN_BASE;
   assign win_hit   = addr >= REG_WIN_BASE && win_off <= 16'(WIN_LAST);
   assign win_aidx  = win_off[5:0];
   assign start_go  = on_request && idle;
   assign cmd_go    = wr_cmd && idle && !on_request;

   // command decode
   logic [5:0] pg_lo, rng_lo, rng_hi;
   logic       cmd_locked, wr_factory, wr_blocked, bad_mem;
   assign pg_lo      = {1'b0, cmd.page, 3'b000};
   assign rng_lo     = cmd.bulk ? (cmd.write ? BOOT_BASE : 6'd0) : pg_lo;
   assign rng_hi     = cmd.bulk ? OTP_LAST : pg_lo + 6'd7;
   assign cmd_locked = otp_r[LOCK_IDX[4:0]][LOCK_BIT];
   assign wr_factory = cmd.write && !cmd.bulk && !cmd.page[1];
   // bulk write still programs pages two and three but reports the factory pages
   assign wr_blocked = cmd.write && cmd_locked;
   assign bad_mem    = !cmd.mem && (cmd.write || cmd.verify || cmd.fin);

   // eeprom engine
   slot_t      slot;
   logic       run, tick, slot_end, smp, last_rx, data_lvl, sda_lvl, scl_lvl;
   logic       ee_we, i2c_fin;
   logic [7:0] tx_byte;
   logic [5:0] rx_k, ee_idx;
   assign run      = (state_r == S_I2C);
   assign tick     = run && div_r == QTR_LAST;
   assign smp      = tick && ph_r == 2'd2;
   assign slot_end = tick && ph_r == 2'd3;
   assign slot     = (step_r == 6'd0 || step_r == ST_RESTART) ? SL_START :
                     (step_r == ST_STOP) ? SL_STOP :
                     (step_r < ST_RX0) ? SL_TX : SL_RX;
   assign tx_byte  = (step_r == 6'd1) ? EE_WR_BYTE :
                     (step_r == ST_RD_DEV) ? EE_RD_BYTE : 8'h00;
   assign last_rx  = (step_r == ST_STOP - 6'd1);
   assign data_lvl = (bit_r == 4'd8) ? (slot == SL_RX ? last_rx : 1'b1) :
                     (slot == SL_TX ? tx_byte[3'd7 - bit_r[2:0]] : 1'b1);
   assign sda_lvl  = (slot == SL_START) ? !ph_r[1] :
                     (slot == SL_STOP) ? ph_r[1] : data_lvl;
   assign scl_lvl  = (slot == SL_STOP) ? ph_r != 2'd0 : ph_r == 2'd1 || ph_r == 2'd2;
   assign rx_k     = step_r - ST_RX0;
   assign ee_idx   = BOOT_BASE + {1'b0, rx_k[5:1]};
   assign ee_we    = slot_end && slot == SL_RX && bit_r == 4'd8 && rx_k[0];
   assign i2c_fin  = slot_end && slot == SL_STOP;

   // window write port
   logic        otp_rd_we, bus_win_we, win_we, vf_miss, otp_end;
   logic [5:0]  win_widx;
   logic [15:0] win_wd;
   assign otp_rd_we  = (state_r == S_OTP) && op_r == OP_RD;
   // factory pages are read-only from the bus side
   assign bus_win_we = wr_en && win_hit && idle && win_aidx >= BOOT_BASE;
   assign win_we     = otp_rd_we || ee_we || bus_win_we;
   assign win_widx   = otp_rd_we ? idx_r : ee_we ? ee_idx : win_aidx;
   assign win_wd     = otp_rd_we ? otp_r[idx_r[4:0]] : ee_we ? {hi_r, sh_r} : wr_data;
   assign vf_miss    = (state_r == S_OTP) && op_r == OP_VF
                       && win_r[idx_r] != otp_r[idx_r[4:0]];
   assign otp_end    = (state_r == S_OTP) && idx_r == end_r;

   // start-up checks
   logic cid_ok, marker_ok, boot_pass;
   assign cid_ok    = win_r[CID_IDX] != 16'h0000;
   assign marker_ok = win_r[MARKER_IDX] == VALID_MARKER && !nack_r;
   assign boot_pass = cid_ok && (!dev_r || marker_ok);

   // bus read mux
   logic [15:0] status, rd_mux;
   assign status = {9'h000, unlock_r, dev_r, fail_r, power_on_r, !idle, err_f_r, done_f_r};
   assign rd_mux = (addr == REG_RESET_RELOAD) ? {reload_r, 15'h0000} :
                   (addr == REG_SECURITY) ? {15'h0000, unlock_r} :
                   (addr == REG_STATUS) ? status :
                   (addr == REG_OTP_CTRL) ? cmd_r :
                   win_hit ? win_r[win_aidx] : 16'h0000;

   generate
      for (genvar i = 0; i < WIN_WORDS; i++) begin : g_win
         always_ff @(posedge clk_sys) begin
            if (!reset_n)
               win_r[i] <= 16'h0000;
            else if (win_we && win_widx == 6'(i))
               win_r[i] <= win_wd;
         end
      end
      // blank part after reset; bits can only be programmed towards one
      for (genvar j = 0; j < OTP_WORDS; j++) begin : g_otp
         always_ff @(posedge clk_sys) begin
            if (!reset_n)
               otp_r[j] <= 16'h0000;
            else if (state_r == S_OTP && op_r == OP_WR && idx_r == 6'(j))
               otp_r[j] <= otp_r[j] | win_r[j];
            else if (cmd_go && cmd.fin && cmd.mem && 6'(j) == LOCK_IDX)
               otp_r[j][LOCK_BIT] <= 1'b1;
         end
      end
   endgenerate

   // pin synchronisers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         scl_s1 <= 1'b0;
         scl_s2 <= 1'b0;
         sda_s1 <= 1'b0;
         sda_s2 <= 1'b0;
      end else begin
         scl_s1 <= aux_serial_clock_pin_in;
         scl_s2 <= scl_s1;
         sda_s1 <= aux_serial_data_pin_in;
         sda_s2 <= sda_s1;
      end
   end

   // registers written by software, plus the read data register
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         reload_r  <= RELOAD_RST;
         unlock_r  <= 1'b0;
         cmd_r     <= '0;
         rd_data_r <= 16'h0000;
      end else begin
         if (wr_reload && unlock_r)
            reload_r <= wr_data[RELOAD_BIT];
         if (wr_key)
            unlock_r <= wr_data == UNLOCK_CODE;
         if (cmd_go)
            cmd_r <= cmd;
         rd_data_r <= rd_en ? rd_mux : 16'h0000;
      end
   end

   // sticky outcome flags, a new event beats a clear in the same cycle
   logic set_done, set_err;
   assign set_done = (state_r == S_DONE);
   assign set_err  = set_done && errp_r;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         done_f_r <= 1'b0;
         err_f_r  <= 1'b0;
      end else begin
         done_f_r <= set_done | (done_f_r & !(wr_stat && wr_data[ST_DONE_BIT]));
         err_f_r  <= set_err | (err_f_r & !(wr_stat && wr_data[ST_ERR_BIT]));
      end
   end

   // sequencer
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r    <= S_IDLE;
         op_r       <= OP_RD;
         ctx_cmd_r  <= 1'b0;
         dev_r      <= 1'b0;
         rl_r       <= 1'b0;
         idx_r      <= 6'd0;
         end_r      <= 6'd0;
         errp_r     <= 1'b0;
         fail_r     <= 1'b0;
         power_on_r <= 1'b0;
         busy_r     <= 1'b0;
      end else begin
         // one cycle behind the state so the pin comes straight from a flop
         busy_r     <= !idle && state_r != S_ON;
         unique case (state_r)
            S_IDLE: begin
               if (start_go) begin
                  dev_r     <= scl_s2;
                  rl_r      <= reload_r;
                  ctx_cmd_r <= 1'b0;
                  fail_r    <= 1'b0;
                  op_r      <= OP_RD;
                  idx_r     <= 6'd0;
                  end_r     <= (reload_r && !scl_s2) ? OTP_LAST : FACT_LAST;
                  state_r   <= S_OTP;
               end else if (cmd_go) begin
                  ctx_cmd_r <= 1'b1;
                  idx_r     <= rng_lo;
                  end_r     <= rng_hi;
                  errp_r    <= bad_mem || wr_factory || (cmd.write && cmd.bulk);
                  if (bad_mem || wr_factory || wr_blocked || cmd.fin)
                     state_r <= S_DONE;
                  else if (cmd.read && !cmd.mem)
                     state_r <= S_I2C;
                  else if (cmd.read || cmd.write || cmd.verify) begin
                     op_r    <= cmd.read ? OP_RD : cmd.write ? OP_WR : OP_VF;
                     state_r <= S_OTP;
                  end
               end
            end
            S_OTP: begin
               if (vf_miss)
                  errp_r <= 1'b1;
               idx_r <= idx_r + 6'd1;
               if (otp_end) begin
                  if (ctx_cmd_r)
                     state_r <= S_DONE;
                  else if (rl_r && dev_r)
                     state_r <= S_I2C;
                  else
                     state_r <= S_CHECK;
               end
            end
            S_I2C: begin
               if (i2c_fin) begin
                  errp_r  <= nack_r;
                  state_r <= ctx_cmd_r ? S_DONE : S_CHECK;
               end
            end
            S_CHECK: begin
               power_on_r <= boot_pass;
               fail_r     <= !boot_pass;
               state_r    <= boot_pass ? S_ON : S_IDLE;
            end
            S_ON: begin
               if (off_request) begin
                  power_on_r <= 1'b0;
                  state_r    <= S_IDLE;
               end
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // eeprom bit engine, quarter-period ticks from a divider
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !run) begin
         div_r    <= 5'd0;
         ph_r     <= 2'd0;
         step_r   <= 6'd0;
         bit_r    <= 4'd0;
         sh_r     <= 8'h00;
         hi_r     <= 8'h00;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         if (!reset_n || start_go || cmd_go)
            nack_r <= 1'b0;
      end else begin
         div_r    <= tick ? 5'd0 : div_r + 5'd1;
         scl_oe_r <= !scl_lvl;
         sda_oe_r <= !sda_lvl;
         if (tick)
            ph_r <= ph_r + 2'd1;
         // no acknowledge means the part is absent or busy
         if (smp && slot == SL_TX && bit_r == 4'd8 && sda_s2)
            nack_r <= 1'b1;
         if (smp && slot == SL_RX && bit_r != 4'd8)
            sh_r <= {sh_r[6:0], sda_s2};
         if (slot_end) begin
            if (slot == SL_START || bit_r == 4'd8) begin
               bit_r  <= 4'd0;
               step_r <= nack_r ? ST_STOP : step_r + 6'd1;
               if (slot == SL_RX && !rx_k[0])
                  hi_r <= sh_r;
            end else begin
               bit_r <= bit_r + 4'd1;
            end
         end
      end
   end

   assign rd_data                  = rd_data_r;
   assign power_on                 = power_on_r;
   assign startup_fail             = fail_r;
   assign busy                     = busy_r;
   assign cmd_done                 = done_f_r;
   assign cmd_err                  = err_f_r;
   // open-drain: only ever pull low
   assign aux_serial_clock_pin_out = 1'b0;
   assign aux_serial_clock_pin_oe  = scl_oe_r;
   assign aux_serial_data_pin_out  = 1'b0;
   assign aux_serial_data_pin_oe   = sda_oe_r;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   localparam int OTP_CMD_MAX = 40;

   chk_fact_first: assert property (
      start_go |=> state_r == S_OTP && op_r == OP_RD && idx_r == 6'd0 && !ctx_cmd_r)
      else $error("start-up did not begin with factory pages");
   chk_strap_sample: assert property (
      start_go |=> dev_r == $past(scl_s2))
      else $error("mode strap not sampled at the ON request");
   chk_boot_source: assert property (
      otp_end && !ctx_cmd_r && rl_r && dev_r |=> state_r == S_I2C)
      else $error("development start-up skipped the eeprom");
   chk_reload_range: assert property (
      otp_end && !ctx_cmd_r |-> end_r == ((rl_r && !dev_r) ? OTP_LAST : FACT_LAST))
      else $error("otp load range ignores the reload bit");
   chk_cid_zero: assert property (
      state_r == S_CHECK && win_r[CID_IDX] == 16'h0000
      |=> !power_on_r && fail_r && state_r == S_IDLE)
      else $error("zero customer id allowed power-up");
   chk_marker_bad: assert property (
      state_r == S_CHECK && dev_r && win_r[MARKER_IDX] != VALID_MARKER |=> fail_r)
      else $error("bad eeprom marker allowed power-up");
   chk_reload_key: assert property (
      wr_reload && !unlock_r |=> $stable(reload_r))
      else $error("locked reload bit changed");
   chk_lock_write: assert property (
      cmd_go && cmd.write && cmd_locked |=> state_r == S_DONE ##1 state_r == S_IDLE)
      else $error("write ran after finalise");
   chk_otp_read_done: assert property (
      cmd_go && cmd.read && cmd.mem && !cmd.fin |-> ##[2:OTP_CMD_MAX] done_f_r)
      else $error("otp read did not complete");

   cov_boot_otp: cover property (start_go && !scl_s2 ##[1:60] power_on_r);
   cov_boot_fail: cover property (state_r == S_CHECK ##1 fail_r);
   cov_ee_word: cover property (ee_we && ee_idx == MARKER_IDX);
   cov_verify_err: cover property (vf_miss ##[1:40] err_f_r);

endmodule : bootstrap_config_loader

// *** verilog/cfg_loader_pkg.sv ***
package cfg_loader_pkg;

   // timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SCL_PERIOD_NS = 800;
   localparam int unsigned QTR_CYCLES    = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                           / (4 * CLK_PERIOD_NS);
   localparam logic [4:0]  QTR_LAST      = 5'(QTR_CYCLES - 1);

   // register map
   localparam logic [15:0] REG_RESET_RELOAD = 16'h4006;
   localparam logic [15:0] REG_SECURITY     = 16'h4007;
   localparam logic [15:0] REG_STATUS       = 16'h4008;
   localparam logic [15:0] REG_OTP_CTRL     = 16'h400a;
   localparam logic [15:0] REG_WIN_BASE     = 16'h7800;

   // fields and reset values
   localparam int unsigned RELOAD_BIT    = 15;
   localparam logic        RELOAD_RST    = 1'b1;
   localparam logic [15:0] UNLOCK_CODE   = 16'h9716;
   localparam logic [15:0] VALID_MARKER  = 16'ha596;
   localparam int unsigned ST_DONE_BIT   = 0;
   localparam int unsigned ST_ERR_BIT    = 1;

   // window and otp layout, in 16-bit words
   localparam int unsigned WIN_WORDS     = 40;
   localparam int unsigned OTP_WORDS     = 32;
   localparam logic [5:0]  WIN_LAST      = 6'd39;
   localparam logic [5:0]  BOOT_BASE     = 6'd16;
   localparam logic [5:0]  FACT_LAST     = 6'd15;
   localparam logic [5:0]  OTP_LAST      = 6'd31;
   localparam logic [5:0]  CID_IDX       = 6'd16;
   localparam logic [5:0]  MARKER_IDX    = 6'd32;
   localparam logic [5:0]  LOCK_IDX      = 6'd23;
   localparam int unsigned LOCK_BIT      = 15;

   // eeprom fetch sequence
   localparam logic [7:0]  EE_WR_BYTE    = 8'ha0;
   localparam logic [7:0]  EE_RD_BYTE    = 8'ha1;
   localparam logic [5:0]  ST_RESTART    = 6'd4;
   localparam logic [5:0]  ST_RD_DEV     = 6'd5;
   localparam logic [5:0]  ST_RX0        = 6'd6;
   localparam logic [5:0]  ST_STOP       = 6'd54;

   typedef struct packed {
      logic [1:0] rsvd_hi;
      logic       mem;
      logic       rsvd_12;
      logic       fin;
      logic       verify;
      logic       write;
      logic       read;
      logic [1:0] read_lvl;
      logic       bulk;
      logic [2:0] rsvd_lo;
      logic [1:0] page;
   } otp_cmd_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_OTP   = 3'b001,
      S_I2C   = 3'b010,
      S_CHECK = 3'b011,
      S_ON    = 3'b100,
      S_DONE  = 3'b101
   } state_t;

   typedef enum logic [1:0] {
      OP_RD = 2'b00,
      OP_WR = 2'b01,
      OP_VF = 2'b10
   } op_t;

   typedef enum logic [1:0] {
      SL_START = 2'b00,
      SL_TX    = 2'b01,
      SL_RX    = 2'b10,
      SL_STOP  = 2'b11
   } slot_t;

endpackage : cfg_loader_pkg
